/* File: rtl/vlm_limit_check.sv */
/*
  Limit comparator for one reading against its channel's high and low limits.
  Assumes the reading and limits are stable registers on the core clock.
*/
`timescale 1ns/1ns
module limit_check #(
  parameter int W = 8
) (
  input wire logic [W-1:0] reading,
  input wire logic [W-1:0] high_limit,
  input wire logic [W-1:0] low_limit,
  output logic above_high,
  output logic below_low
);
  // Strict comparisons: a reading equal to a limit is in range.
  assign above_high = reading > high_limit; // RULE10
  assign below_low = reading < low_limit; // RULE10
endmodule

/* File: rtl/vlm_pkg.sv */
/*
  Constants for the voltage level monitor scan control: channel counts,
  channel numbering, converter width and timing figures.
  Assumes a single 20 MHz core clock and no register bus.
*/
package monitor_pkg;
  localparam int NUM_CH = 14;
  localparam int NUM_VOLT_CH = 11;
  localparam int LAST_VOLT_CH = 10;
  localparam int FIRST_CH = 0;
  localparam int RES_W = 8;
  localparam logic [7:0] RES_MIN = 8'h00;
  localparam logic [7:0] RES_MAX = 8'hFF;
  localparam int EXT_CH_FIRST = 0;
  localparam int EXT_CH_LAST = 6;
  localparam int CH_STANDBY_SUPPLY = 7;
  localparam int CH_MAIN_SUPPLY = 8;
  localparam int CH_BATTERY = 9;
  localparam int CH_ANALOG_SUPPLY = 10;
  localparam int CH_THERM_ONE = 11;
  localparam int CH_THERM_TWO = 12;
  localparam int CH_THERM_THREE = 13;
  localparam logic [13:0] HALF_SCALE_MASK = 14'h0580;
  localparam int CLK_HZ = 20000000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PERIOD_CNT_W = 24;
  localparam int SETTLE_CNT_W = 16;
  localparam int CONV_TIMEOUT_US = 100;
  localparam int CONV_TIMEOUT_CYC = (CONV_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
endpackage

/* File: rtl/voltage_level_monitor.sv */
/*
  Scan control for a 14-channel voltage level monitor around an 8-bit
  converter: periodic burst trigger, settling delay, per-channel readouts,
  sticky limit status, alarm, IRQ and SMI summaries.
  Assumes an external converter with a start/done handshake on core_clk;
  the sleep-state pin is asynchronous and is synchronised here.
*/
// Overview of operation
// (RULE1) Fourteen channels: seven external, four internal, three thermistor.
// (RULE2) Standby, main, analog supply readouts are halved.
// (RULE3) Three thermistor inputs convert like voltage channels.
// (RULE4) Period trigger starts burst from channel zero.
// (RULE5) Settling delay between consecutive conversions.
// (RULE6) Unsigned 8-bit result stored per-channel readout.
// (RULE7) Sleep input or error halts conversion.
// (RULE8) Out-of-range voltage channel suspended until cleared.
// (RULE9) Systems lacking sleep signal tie input high.
// (RULE10) Compare reading with high and low limits.
// (RULE11) Limit status bits sticky until software clears.
// (RULE12) Limit bit sets channel alarm event bit.
// (RULE13) Alarm drives interrupt, pin, or both.
// (RULE14) Alarm pin needs enable and limit bit.
// (RULE15) SMI active when status and enable set.
// (RULE16) IRQ active when status and enable set.
// (RULE17) Standby blocks new measurements, keeps registers.
// (RULE18) Disabled channels skipped, burst ends after last.
`timescale 1ns/1ns
module voltage_level_monitor #(
  parameter int NUM_CH = monitor_pkg::NUM_CH,
  parameter int NUM_VOLT_CH = monitor_pkg::NUM_VOLT_CH,
  parameter int RES_W = monitor_pkg::RES_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sleep_state_input_n,
  input wire logic standby_enable,
  input wire logic monitor_enable,
  input wire logic [23:0] conversion_period,
  input wire logic [15:0] settle_delay,
  input wire logic [13:0] channel_enable,
  input wire logic [13:0] alarm_out_enable,
  input wire logic [111:0] high_limit,
  input wire logic [111:0] low_limit,
  input wire logic [13:0] clear_high,
  input wire logic [13:0] clear_low,
  input wire logic [13:0] event_smi_enable,
  input wire logic [13:0] event_irq_enable,
  input wire logic [13:0] event_clear,
  input wire logic error_clear,
  output logic conv_start,
  output logic [3:0] conv_channel,
  output logic conv_half_scale,
  input wire logic conv_done,
  input wire logic [7:0] conv_result,
  output logic [111:0] channel_readout,
  output logic [13:0] status_high,
  output logic [13:0] status_low,
  output logic [13:0] event_status,
  output logic [6:0] event_status_low,
  output logic [6:0] event_status_high,
  output logic error_held,
  output logic scan_busy,
  output logic alarm_pin_n,
  output logic irq,
  output logic smi_n
);
  // The channel map and the field slicing below are fixed at fourteen 8-bit channels.
  if (NUM_CH != monitor_pkg::NUM_CH || RES_W != monitor_pkg::RES_W ||
      NUM_VOLT_CH != monitor_pkg::NUM_VOLT_CH) begin : g_bad_layout
    $error("voltage_level_monitor: only the fourteen channel layout is supported");
  end

  typedef enum logic [2:0] {S_IDLE, S_SEEK, S_SETTLE, S_CONVERT, S_STORE} scan_state_t;

  // Returns the lowest eligible channel at or above start, or NUM_CH if none.
  function automatic logic [4:0] next_channel(input logic [13:0] elig, input logic [4:0] start);
    logic [4:0] found;
    found = 5'(monitor_pkg::NUM_CH);
    for (int i = monitor_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (elig[i] && 5'(i) >= start) begin
        found = 5'(i);
      end
    end
    return found;
  endfunction

  scan_state_t state_q;
  logic sleep_meta_q;
  logic sleep_sync_q;
  logic [23:0] period_cnt_q;
  logic trigger_q;
  logic [15:0] settle_cnt_q;
  logic [4:0] chan_q;
  logic [7:0] result_q;
  logic [31:0] timeout_q;
  logic error_q;
  logic [13:0] stat_hi_q;
  logic [13:0] stat_lo_q;
  logic [13:0] event_q;
  logic [111:0] readout_q;
  logic halted;
  logic [13:0] suspended;
  logic [13:0] eligible;
  logic [4:0] next_ch;
  logic cur_above;
  logic cur_below;
  logic [3:0] cur_idx;

  // The pin is asynchronous; only the second stage is read by logic.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleep_meta_q <= 1'b1;
      sleep_sync_q <= 1'b1;
    end else begin
      sleep_meta_q <= sleep_state_input_n;
      sleep_sync_q <= sleep_meta_q;
    end
  end

  // Low on the sleep input means supply loss is expected; a board without
  // the signal ties it high so conversions run.
  assign halted = !sleep_sync_q || error_q || standby_enable || !monitor_enable; // RULE7 RULE9 RULE17

  // Voltage channels keep their alarm evidence by not being reconverted.
  // Clearing the event bit is what releases a suspended channel; clearing only
  // the limit bits is not enough while the event bit stays set.
  assign suspended = {3'b000, event_q[10:0]}; // RULE8
  assign eligible = channel_enable & ~suspended; // RULE18 RULE1 RULE3
  assign next_ch = next_channel(eligible, chan_q);
  assign cur_idx = chan_q[3:0];

  limit_check #(.W(RES_W)) u_limit (
    .reading(result_q),
    .high_limit(high_limit[cur_idx*8 +: 8]),
    .low_limit(low_limit[cur_idx*8 +: 8]),
    .above_high(cur_above),
    .below_low(cur_below)
  );

  // Period counter: a zero period disables triggering.
  // The counter restarts after any halt, so the first burst after resuming comes
  // one full period later rather than at once.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_cnt_q <= 24'h000000;
      trigger_q <= 1'b0;
    end else if (halted || conversion_period == 24'h000000) begin
      period_cnt_q <= 24'h000000;
      trigger_q <= 1'b0;
    end else if (period_cnt_q >= conversion_period - 24'h000001) begin
      period_cnt_q <= 24'h000000;
      trigger_q <= 1'b1; // RULE4
    end else begin
      period_cnt_q <= period_cnt_q + 24'h000001;
      trigger_q <= 1'b0;
    end
  end

  // Scan sequencer.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      chan_q <= 5'h00;
      settle_cnt_q <= 16'h0000;
      result_q <= 8'h00;
      timeout_q <= 32'h00000000;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (trigger_q && !halted) begin
            chan_q <= 5'(monitor_pkg::FIRST_CH); // RULE4
            state_q <= S_SEEK;
          end
        end
        S_SEEK: begin
          if (halted || next_ch == 5'(monitor_pkg::NUM_CH)) begin
            state_q <= S_IDLE; // RULE18
          end else begin
            chan_q <= next_ch; // RULE18
            timeout_q <= 32'h00000000;
            state_q <= S_CONVERT;
          end
        end
        S_CONVERT: begin
          // A started conversion runs to its end even if a halt arrives, so the
          // converter is never abandoned mid-cycle; the halt acts in the settling step that follows.
          timeout_q <= timeout_q + 32'h00000001;
          if (conv_done) begin
            result_q <= conv_result; // RULE6
            state_q <= S_STORE;
          end else if (timeout_q >= 32'(monitor_pkg::CONV_TIMEOUT_CYC)) begin
            state_q <= S_IDLE;
          end
        end
        S_STORE: begin
          // Readout and status writes use the channel index before it advances here.
          settle_cnt_q <= settle_delay;
          chan_q <= chan_q + 5'h01;
          state_q <= S_SETTLE;
        end
        S_SETTLE: begin
          if (halted) begin
            state_q <= S_IDLE;
          end else if (settle_cnt_q == 16'h0000) begin
            state_q <= S_SEEK; // RULE5
          end else begin
            settle_cnt_q <= settle_cnt_q - 16'h0001; // RULE5
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // A converter that never answers is an error; it holds off conversion.
  // The clear only releases the hold; the next burst still waits for a trigger.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      error_q <= 1'b0;
    end else if (state_q == S_CONVERT && !conv_done &&
                 timeout_q >= 32'(monitor_pkg::CONV_TIMEOUT_CYC)) begin
      error_q <= 1'b1; // RULE7
    end else if (error_clear) begin
      error_q <= 1'b0;
    end
  end

  // Readouts update only on a stored result, so halting freezes them.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      readout_q <= '0;
    end else if (state_q == S_STORE) begin
      readout_q[cur_idx*8 +: 8] <= result_q; // RULE6 RULE2
    end
  end

  // Sticky limit bits; a new exceedance in the clear cycle wins.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stat_hi_q <= 14'h0000;
      stat_lo_q <= 14'h0000;
    end else begin
      // Clears are levels; holding one high masks the bit but never blocks a set.
      for (int i = 0; i < monitor_pkg::NUM_CH; i++) begin
        if (state_q == S_STORE && cur_idx == 4'(i) && cur_above) begin
          stat_hi_q[i] <= 1'b1; // RULE10 RULE11
        end else if (clear_high[i]) begin
          stat_hi_q[i] <= 1'b0; // RULE11
        end
        if (state_q == S_STORE && cur_idx == 4'(i) && cur_below) begin
          stat_lo_q[i] <= 1'b1; // RULE10 RULE11
        end else if (clear_low[i]) begin
          stat_lo_q[i] <= 1'b0; // RULE11
        end
      end
    end
  end

  // Event alarm bits follow limit bits; a set limit bit re-raises it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_q <= 14'h0000;
    end else begin
      for (int i = 0; i < monitor_pkg::NUM_CH; i++) begin
        if (stat_hi_q[i] || stat_lo_q[i]) begin
          event_q[i] <= 1'b1; // RULE12
        end else if (event_clear[i]) begin
          event_q[i] <= 1'b0;
        end
      end
    end
  end

  // Summary outputs are registered so they never glitch.
  // The price is one cycle of latency from the event bit to irq and smi_n, and from the limit bits to the alarm pin.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alarm_pin_n <= 1'b1;
      irq <= 1'b0;
      smi_n <= 1'b1;
    end else begin
      alarm_pin_n <= ~|(alarm_out_enable & (stat_hi_q | stat_lo_q)); // RULE14 RULE13
      irq <= |(event_q & event_irq_enable); // RULE16 RULE13
      smi_n <= ~|(event_q & event_smi_enable); // RULE15
    end
  end

  assign conv_start = (state_q == S_CONVERT) && (timeout_q == 32'h00000000);
  assign conv_channel = cur_idx;
  // Past the last channel the index leaves the map; gating keeps the pin defined
  // while the sequencer idles.
  assign conv_half_scale = (chan_q < 5'(monitor_pkg::NUM_CH)) &&
                           monitor_pkg::HALF_SCALE_MASK[cur_idx]; // RULE2
  assign channel_readout = readout_q;
  assign status_high = stat_hi_q;
  assign status_low = stat_lo_q;
  assign event_status = event_q;
  assign event_status_low = event_q[6:0];
  assign event_status_high = event_q[13:7];
  assign error_held = error_q;
  assign scan_busy = state_q != S_IDLE;
endmodule

/* File: verification/adc_model.sv */
/*
  Converter stand-in: answers each start six cycles later, halving when asked.
  Assumes one start at a time; mute withholds the answer to provoke a timeout.
*/
`timescale 1ns/1ns
module adc_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic conv_half_scale,
  input wire logic [111:0] level,
  input wire logic mute,
  output logic conv_done,
  output logic [7:0] conv_result
);
  logic [3:0] wait_q;
  logic [7:0] val_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_q <= 4'h0;
      val_q <= 8'h00;
      conv_done <= 1'h0;
      conv_result <= 8'h00;
    end else begin
      conv_done <= wait_q == 4'h1;
      // Between answers the data toggles, so a late sample cannot look right.
      conv_result <= wait_q == 4'h1 ? val_q : ~conv_result;
      wait_q <= wait_q == 4'h0 ? 4'h0 : wait_q - 4'h1;
      if (conv_start && !mute) begin
        wait_q <= 4'h6;
        val_q <= level[conv_channel * 8 +: 8] >> conv_half_scale;
      end
    end
  end
endmodule

/* File: verification/tb.sv */
/*
  Self-checking bench: bursts, skipping, limits, halts and converter timeout.
  Assumes the converter stand-in in adc_model.sv.
*/
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'h0, rst = 1'h1, standby_enable = 1'h0, monitor_enable = 1'h1;
  logic sleep_state_input_n = 1'h1;
  logic error_clear = 1'h0, mute = 1'h0;
  logic [23:0] conversion_period = 24'h000190;
  logic [15:0] settle_delay = 16'h0005;
  logic [13:0] channel_enable = 14'h3FFF, alarm_out_enable = 14'h0000, event_clear = 14'h0000;
  logic [13:0] clear_high = 14'h0000, clear_low = 14'h0000;
  logic [13:0] event_smi_enable = 14'h0000, event_irq_enable = 14'h0000;
  logic [111:0] high_limit = {14{8'hFF}}, low_limit = 112'h0, level, channel_readout;
  logic conv_start, conv_half_scale, conv_done, error_held, scan_busy, alarm_pin_n, irq, smi_n;
  logic [3:0] conv_channel, cur;
  logic [7:0] conv_result;
  logic [7:0] ro_exp [14];
  logic [13:0] status_high, status_low, event_status;
  logic [6:0] event_status_low, event_status_high;
  logic [3:0] seq [$];
  int n_mismatch = 0, compares = 0, gap = 0, starts = 0;
  voltage_level_monitor dut (.core_clk, .rst, .sleep_state_input_n, .standby_enable,
    .monitor_enable, .conversion_period, .settle_delay, .channel_enable, .alarm_out_enable,
    .high_limit, .low_limit, .clear_high, .clear_low, .event_smi_enable, .event_irq_enable,
    .event_clear, .error_clear, .conv_start, .conv_channel, .conv_half_scale, .conv_done,
    .conv_result, .channel_readout, .status_high, .status_low, .event_status, .event_status_low,
    .event_status_high, .error_held, .scan_busy, .alarm_pin_n, .irq, .smi_n);
  adc_model adc (.core_clk, .rst, .conv_start, .conv_channel, .conv_half_scale, .level, .mute,
    .conv_done, .conv_result);
  always #25 core_clk = ~core_clk;
  function automatic logic [7:0] fx(int c);
    fx = level[c * 8 +: 8];
    if (c == 7 || c == 8 || c == 10) fx = {1'h0, fx[7:1]};
  endfunction
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Gap counts cycles from the last answer, so it only means something inside a burst.
  always @(posedge core_clk) begin
    gap <= conv_done ? 0 : gap + 1;
    if (conv_done) ro_exp[cur] = fx(cur);
    if (conv_start) begin
      if (seq.size() > 0) check(24'(gap), 24'(settle_delay) + 24'h3, "settle gap");
      seq.push_back(conv_channel);
      cur = conv_channel;
      starts <= starts + 1;
    end
  end
  task automatic run_burst(input logic [13:0] susp);
    int n = 0;
    logic [3:0] q [$];
    seq = {};
    for (int i = 0; i < 14; i++) if (channel_enable[i] && !(i <= 10 && susp[i])) q.push_back(4'(i));
    while (!scan_busy && n < 900) begin
      tick(1);
      n++;
    end
    while (scan_busy && n < 1800) begin
      tick(1);
      n++;
    end
    check(24'(scan_busy), 24'h000000, "burst ended");
    check(24'(seq.size()), 24'(q.size()), "burst length");
    foreach (q[i]) check(24'(seq[i]), 24'(q[i]), "channel order");
    for (int i = 0; i < 14; i++) check(24'(channel_readout[i * 8 +: 8]), 24'(ro_exp[i]), "readout");
  endtask
  task automatic t_skip;
    channel_enable = 14'h2A55;
    settle_delay = 16'h0009;
    level = ~level;
    run_burst(14'h0000);
    channel_enable = 14'h3FFF;
  endtask
  task automatic t_limits;
    high_limit[31:24] = level[31:24] - 8'h01;
    high_limit[95:88] = level[95:88];
    low_limit[103:96] = level[103:96] + 8'h01;
    alarm_out_enable = 14'h0008;
    event_irq_enable = 14'h0008;
    event_smi_enable = 14'h1000;
    run_burst(14'h0000);
    tick(3);
    check(24'(status_high), 24'h000008, "high status");
    check(24'(status_low), 24'h001000, "low status");
    check(24'({event_status_high, event_status_low}), 24'h001008, "events");
    check(24'({irq, smi_n, alarm_pin_n}), 24'h000004, "alarm outputs");
    high_limit = {14{8'hFF}};
    low_limit = 112'h0;
    run_burst(14'h0008);
    check(24'(status_high | status_low), 24'h001008, "sticky status");
    clear_high = 14'h0008;
    clear_low = 14'h1000;
    tick(1);
    clear_high = 14'h0000;
    clear_low = 14'h0000;
    event_clear = 14'h1008;
    tick(1);
    event_clear = 14'h0000;
    tick(3);
    check(24'({event_status, irq, smi_n, alarm_pin_n}), 24'h000003, "cleared");
  endtask
  task automatic t_halt;
    int s;
    for (int k = 0; k < 4; k++) begin
      conversion_period = k == 3 ? 24'h000000 : 24'h000190;
      sleep_state_input_n = k != 0;
      standby_enable = k == 1;
      monitor_enable = k != 2;
      s = starts;
      tick(1000);
      check(24'(starts - s), 24'h0, "halted starts");
    end
    monitor_enable = 1'h1;
    conversion_period = 24'h000190;
    run_burst(14'h0000);
  endtask
  task automatic t_error;
    int s = 0;
    mute = 1'h1;
    seq = {};
    while (!error_held && s < 3000) begin
      tick(1);
      s++;
    end
    tick(3);
    check(24'({error_held, scan_busy}), 24'h000002, "error held");
    s = starts;
    tick(1000);
    check(24'(starts - s), 24'h0, "starts in error");
    mute = 1'h0;
    error_clear = 1'h1;
    tick(1);
    error_clear = 1'h0;
    run_burst(14'h0000);
  endtask
  task automatic wrap_up;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 14; i++) begin
      level[i * 8 +: 8] = 8'(i * 19);
      ro_exp[i] = 8'h00;
    end
    tick(16);
    rst = 1'h0;
    run_burst(14'h0000);
    t_skip;
    t_limits;
    t_halt;
    t_error;
    wrap_up;
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    n_mismatch++;
    wrap_up;
  end
endmodule

/* File: verification/vlm_assertions.sv */
/*
  Port checks for the scan control.
  Assumes one core clock and an active-high asynchronous reset.
*/
`timescale 1ns/1ns
module scan_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standby_enable,
  input wire logic [13:0] channel_enable,
  input wire logic [13:0] alarm_out_enable,
  input wire logic [13:0] clear_high,
  input wire logic [13:0] clear_low,
  input wire logic [13:0] event_smi_enable,
  input wire logic [13:0] event_irq_enable,
  input wire logic [13:0] event_clear,
  input wire logic conv_start,
  input wire logic [3:0] conv_channel,
  input wire logic conv_half_scale,
  input wire logic [13:0] status_high,
  input wire logic [13:0] status_low,
  input wire logic [13:0] event_status,
  input wire logic alarm_pin_n,
  input wire logic irq,
  input wire logic smi_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_start_enabled: assert property (conv_start |-> channel_enable[conv_channel])
    else $error("start on a disabled channel");
  a_half_scale_map: assert property (conv_start |->
    conv_half_scale == (conv_channel inside {4'h7, 4'h8, 4'hA})) else $error("half scale wrong");
  a_standby_no_start: assert property (standby_enable [*4] |-> !conv_start)
    else $error("start during standby");
  a_sticky_high: assert property (($past(status_high) & ~status_high & ~$past(clear_high))
    == 14'h0000) else $error("high status dropped");
  a_sticky_low: assert property (($past(status_low) & ~status_low & ~$past(clear_low))
    == 14'h0000) else $error("low status dropped");
  a_event_follow: assert property (($past(status_high | status_low) & ~event_status
    & ~$past(event_clear)) == 14'h0000) else $error("event bit missing");
  a_irq_map: assert property (irq == $past(|(event_status & event_irq_enable)))
    else $error("irq wrong");
  a_smi_map: assert property (smi_n == !$past(|(event_status & event_smi_enable)))
    else $error("smi wrong");
  a_alarm_on: assert property (|((status_high | status_low) & alarm_out_enable) [*3]
    |-> !alarm_pin_n) else $error("alarm pin idle");
  c_start: cover property (conv_start);
  c_irq: cover property (irq);
  c_alarm: cover property (!alarm_pin_n);
endmodule

bind voltage_level_monitor scan_checker chk (.core_clk, .rst, .standby_enable, .channel_enable,
  .alarm_out_enable, .clear_high, .clear_low, .event_smi_enable, .event_irq_enable, .event_clear,
  .conv_start, .conv_channel, .conv_half_scale, .status_high, .status_low, .event_status,
  .alarm_pin_n, .irq, .smi_n);
